// ===== testbench.sv
`include "ttm_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        poke = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] val = 32'h0100_0000;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic [31:0] meas;
  logic        ack;
  logic        irq;
  logic        sreq;
  logic        vld;
  logic        intol;
  logic        opc;
  int          checks = 0;
  int          n_mismatch = 0;

  // short counts: 4 cycles per ms, a sample request every 20 cycles
  ttm_top #(.MS_CYC(4), .SAMPLE_CYC(20)) dut (
    .SYS_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack),
    .IRQ_O(irq), .MEAS_VLD_I(vld), .MEAS_I(meas), .SAMPLE_REQ_O(sreq),
    .IN_TOL_O(intol), .OPC_O(opc));
  ttm_sensor_model #(.LAG(2)) sensor (.clk_i(clk), .req_i(sreq),
    .poke_i(poke), .value_i(val), .vld_o(vld), .meas_o(meas));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; the request stands until ack is sampled, and only
  // the watchdog ends a wait for an answer that never comes
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    chk(ack, 0);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // new sample value, and ask the sensor for it at once
  task automatic sample(input logic [31:0] v);
    val <= v;
    poke <= 1'b1;
    @(posedge clk);
    poke <= 1'b0;
  endtask

  task automatic t_reset;
    rdchk(`TTM_OFS_BAND, 32'h0000_0002);
    rdchk(`TTM_OFS_DWELL, 32'h0000_1388);
    rdchk(`TTM_OFS_COND, 32'h0000_0000);
    rdchk(8'h40, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_period;
    int n;
    for (n = 0; n < 30 && sreq !== 1'b1; n++)
      @(posedge clk);
    for (n = 1; n < 40; n++)
    begin
      @(posedge clk);
      if (sreq === 1'b1)
        break;
    end
    chk(n, 20);
    $display("test period done");
  endtask

  // out-of-range writes leave the old value and flag a rejected write
  task automatic t_limits;
    logic [7:0]  o [6] = '{`TTM_OFS_BAND, `TTM_OFS_BAND, `TTM_OFS_BAND,
                           `TTM_OFS_DWELL, `TTM_OFS_DWELL, `TTM_OFS_DWELL};
    logic [31:0] v [6] = '{32'h0000_0000, 32'h0000_0065, 32'h0000_0064,
                           32'h0000_0000, 32'h0000_C351, 32'h0000_C350};
    logic [31:0] e [6] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0064,
                           32'h0000_1388, 32'h0000_1388, 32'h0000_C350};
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, o[i], v[i]);
      rdchk(o[i], e[i]);
    end
    rdchk(`TTM_OFS_EVSTAT, 32'h0000_0004);
    wb(1'b1, `TTM_OFS_EVCLR, 32'h0000_0007);
    rdchk(`TTM_OFS_EVSTAT, 32'h0000_0000);
    wb(1'b1, `TTM_OFS_BAND, 32'h0000_0001);
    wb(1'b1, `TTM_OFS_DWELL, 32'h0000_0005);
    $display("test limits done");
  endtask

  task automatic t_dwell;
    int n;
    wb(1'b1, `TTM_OFS_EVEN, 32'h0000_0003);
    wb(1'b1, `TTM_OFS_SETPT, 32'h0003_D090);
    wb(1'b1, `TTM_OFS_CTRL, 32'h0000_0001);
    sample(32'h0003_D478);
    chk(opc, 0);
    for (n = 1; n < 60 && intol !== 1'b1; n++)
      @(posedge clk);
    chk(n >= 20 && n <= 28, 1);
    repeat (2) @(posedge clk);
    chk(opc, 1);
    chk(irq, 1);
    sample(32'h0003_D479);
    repeat (6) @(posedge clk);
    chk(intol, 0);
    rdchk(`TTM_OFS_EVSTAT, 32'h0000_0003);
    rdchk(`TTM_OFS_MEAS, 32'h0003_D479);
    wb(1'b1, `TTM_OFS_EVCLR, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    $display("test dwell done");
  endtask

  // the fixed 10 mA band in current mode, the programmed band elsewhere
  task automatic t_modes;
    logic [31:0] off [2] = '{32'h0000_01F4, 32'h0000_0032};
    for (int m = 0; m < 3; m++)
      for (int k = 0; k < 2; k++)
      begin
        wb(1'b1, `TTM_OFS_CTRL, {29'h0000_0000, 2'(m), 1'b1});
        wb(1'b1, `TTM_OFS_SETPT, 32'hFFFF_87C6);
        chk(intol, 0);
        chk(opc, 0);
        sample(32'hFFFF_87C6 + off[k]);
        repeat (40) @(posedge clk);
        chk(intol, k == 1 || m != 2);
        chk(opc, k == 1 || m != 2);
        rdchk(`TTM_OFS_MEAS, 32'hFFFF_87C6 + off[k]);
      end
    $display("test modes done");
  endtask

  // a reset in mid-run drops tolerance and brings back the default window
  task automatic t_rerst;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(intol, 0);
    chk(opc, 0);
    rdchk(`TTM_OFS_BAND, 32'h0000_0002);
    rdchk(`TTM_OFS_DWELL, 32'h0000_1388);
    $display("test rerst done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_period();
    t_limits();
    t_dwell();
    t_modes();
    t_rerst();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== ttm_pkg.sv
`default_nettype none
package ttm_pkg;
  // tolerance tracking states
  typedef enum logic [1:0] {ST_OUT, ST_DWELL, ST_IN} ttm_tol_st_t;

  // whole state of the monitor
  typedef struct packed {
    logic              ack;
    logic [31:0]       dat;
    logic              irq;
    logic              out_on;
    logic [1:0]        mode;
    logic [31:0]       setpt;
    logic [7:0]        band;
    logic [15:0]       dwell;
    logic [31:0]       meas;
    ttm_tol_st_t       st;
    logic              in_tol;
    logic              opc;
    logic              opc_pend;
    logic [2:0]        ev;
    logic [2:0]        ev_en;
    logic [31:0]       ms_cnt;
    logic [15:0]       dwell_cnt;
    logic [31:0]       samp_cnt;
    logic              samp_req;
  } ttm_state_t;
endpackage
`default_nettype wire

// ===== ttm_regs.svh
`ifndef TTM_REGS_SVH
`define TTM_REGS_SVH

// register byte offsets on the wishbone slave
`define TTM_OFS_CTRL     8'h00
`define TTM_OFS_SETPT    8'h04
`define TTM_OFS_BAND     8'h08
`define TTM_OFS_DWELL    8'h0C
`define TTM_OFS_MEAS     8'h10
`define TTM_OFS_COND     8'h14
`define TTM_OFS_EVSTAT   8'h18
`define TTM_OFS_EVCLR    8'h1C
`define TTM_OFS_EVEN     8'h20

// field positions
`define TTM_CTRL_ON      0
`define TTM_CTRL_MODE_LO 1
`define TTM_COND_OPC     0
`define TTM_COND_INTOL   9
`define TTM_EV_ENTER     0
`define TTM_EV_EXIT      1
`define TTM_EV_REJECT    2

// cooler control modes
`define TTM_MODE_T       2'h0
`define TTM_MODE_R       2'h1
`define TTM_MODE_ITE     2'h2

// band in 0.1 degC steps, dwell in ms, measured value in 1e-4 units
`define TTM_BAND_MIN     8'h01
`define TTM_BAND_MAX     8'h64
`define TTM_BAND_RST     8'h02
`define TTM_DWELL_MIN    16'h0001
`define TTM_DWELL_MAX    16'hC350
`define TTM_DWELL_RST    16'h1388
`define TTM_BAND_SCALE   33'h0_0000_03E8
`define TTM_ITE_BAND     33'h0_0000_0064

// timing
`define TTM_CLK_HZ       125000000
`define TTM_SAMPLE_MS    400
`define TTM_MS_CYC       (`TTM_CLK_HZ / 1000)
`define TTM_SAMPLE_CYC   (`TTM_MS_CYC * `TTM_SAMPLE_MS)

`endif

// ===== ttm_sensor_model.sv
`default_nettype none
// stand-in for the sensor front end that answers sample requests
module ttm_sensor_model #(
  parameter int LAG = 2
) (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        poke_i,
  input  wire logic [31:0] value_i,
  output logic             vld_o,
  output logic [31:0]      meas_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q = 0;
  initial vld_o = 1'b0;
  initial meas_o = 32'h0000_0000;
  // answer LAG cycles after a request; the data bus toggles outside
  // the valid cycle so a stale sample can never pass for a fresh one
  always @(posedge clk_i)
  begin
    vld_o <= (wait_q == 1);
    meas_o <= (wait_q == 1) ? value_i : ~meas_o;
    if (req_i || poke_i)
      wait_q <= LAG;
    else if (wait_q != 0)
      wait_q <= wait_q - 1;
  end
endmodule
`default_nettype wire

// ===== ttm_top.sv
// How it works
// RULE1 - a sample request pulses every 400 ms and each returned sample feeds the band check.
// RULE2 - the measured value is latched on every sample whatever the control mode.
// RULE3 - the measured value is kept in 1e-4 units on 32 signed bits so six digits survive.
// RULE4 - the band half-width is accepted only from 0.1 to 10.0 degC; other writes are refused.
// RULE5 - the dwell window is accepted only from 0.001 to 50.0 s; other writes are refused.
// RULE6 - after reset the band is 0.2 degC and the dwell window 5 s until software changes them.
// RULE7 - in current mode a fixed 10 mA band replaces the programmed band; dwell still applies.
// RULE8 - in resistance mode the programmed band and dwell apply exactly as in temperature mode.
// RULE9 - condition bit 9 sets only after the value stayed in band for the whole dwell window.
// RULE10 - output switch-on or a set point change holds operation-complete until in tolerance.
// RULE11 - entering and leaving tolerance are both latched as sticky events that can interrupt.
// RULE12 - software reads the band and then the dwell window back from two registers.
// RULE13 - a sample out of band or a set point change restarts the dwell and clears bit 9.
`include "ttm_regs.svh"
`default_nettype none
module ttm_top #(
  parameter int unsigned MS_CYC     = `TTM_MS_CYC,
  parameter int unsigned SAMPLE_CYC = `TTM_SAMPLE_CYC
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  output logic             IRQ_O,
  input  wire logic        MEAS_VLD_I,
  input  wire logic [31:0] MEAS_I,
  output logic             SAMPLE_REQ_O,
  output logic             IN_TOL_O,
  output logic             OPC_O
);

  ttm_pkg::ttm_state_t s_q;
  ttm_pkg::ttm_state_t s_d;

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // magnitude of the error between measurement and set point
  function automatic logic [32:0] abs_err(input logic [31:0] a, input logic [31:0] b);
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    return d[32] ? 33'(-d) : 33'(d);
  endfunction

  // band limit in measurement units for the current mode
  function automatic logic [32:0] band_lim(input logic [1:0] mode, input logic [7:0] band);
    logic [32:0] r;
    if (mode == `TTM_MODE_ITE)
      r = `TTM_ITE_BAND;                             // see RULE7
    else
      r = 33'(band) * `TTM_BAND_SCALE;               // see RULE8
    return r;
  endfunction

  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] wv;
  logic        in_band;
  logic        setpt_wr;
  logic        on_rise;
  logic [2:0]  ev_set;

  // a bus access is answered one cycle after strobe; ack drops the cycle after
  assign acc      = CYC_I && STB_I && !s_q.ack;
  assign wr       = acc && WE_I;
  assign rd       = acc && !WE_I;
  assign in_band  = abs_err(MEAS_I, s_q.setpt) <= band_lim(s_q.mode, s_q.band);
  assign setpt_wr = wr && ADR_I == `TTM_OFS_SETPT;
  assign on_rise  = wr && ADR_I == `TTM_OFS_CTRL && SEL_I[0]
                    && DAT_I[`TTM_CTRL_ON] && !s_q.out_on;

  // next state: bus, sampling, dwell timing, completion and events
  always_comb
  begin
    s_d        = s_q;
    wv         = wb_merge(32'h0000_0000, DAT_I, SEL_I);
    ev_set     = 3'h0;
    s_d.ack    = acc;
    s_d.dat    = 32'h0000_0000;
    s_d.samp_req = 1'b0;

    // periodic sample request
    if (s_q.samp_cnt >= 32'(SAMPLE_CYC - 1))
    begin
      s_d.samp_cnt = 32'h0000_0000;
      s_d.samp_req = 1'b1;                           // see RULE1
    end
    else
      s_d.samp_cnt = s_q.samp_cnt + 32'h0000_0001;

    // register writes
    if (wr)
    begin
      case (ADR_I)
        `TTM_OFS_CTRL:
        begin
          if (SEL_I[0])
          begin
            s_d.out_on = DAT_I[`TTM_CTRL_ON];
            s_d.mode   = DAT_I[`TTM_CTRL_MODE_LO +: 2];
          end
        end
        `TTM_OFS_SETPT: s_d.setpt = wb_merge(s_q.setpt, DAT_I, SEL_I);
        `TTM_OFS_BAND:
        begin
          // out-of-range values leave the old band in place
          if (wv[7:0] >= `TTM_BAND_MIN && wv[7:0] <= `TTM_BAND_MAX && wv[31:8] == 24'h0)
            s_d.band = wv[7:0];                      // see RULE4
          else
            ev_set[`TTM_EV_REJECT] = 1'b1;
        end
        `TTM_OFS_DWELL:
        begin
          if (wv[15:0] >= `TTM_DWELL_MIN && wv[15:0] <= `TTM_DWELL_MAX
              && wv[31:16] == 16'h0)
            s_d.dwell = wv[15:0];                    // see RULE5
          else
            ev_set[`TTM_EV_REJECT] = 1'b1;
        end
        `TTM_OFS_EVEN: s_d.ev_en = wv[2:0];
        default: ;
      endcase
    end

    // register reads; unmapped addresses answer zero
    if (rd)
    begin
      case (ADR_I)
        `TTM_OFS_CTRL:   s_d.dat = {29'h0, s_q.mode, s_q.out_on};
        `TTM_OFS_SETPT:  s_d.dat = s_q.setpt;
        `TTM_OFS_BAND:   s_d.dat = {24'h0, s_q.band};             // see RULE12
        `TTM_OFS_DWELL:  s_d.dat = {16'h0, s_q.dwell};            // see RULE12
        `TTM_OFS_MEAS:   s_d.dat = s_q.meas;                      // see RULE3
        `TTM_OFS_COND:   s_d.dat = {22'h0, s_q.in_tol, 8'h0, s_q.opc};
        `TTM_OFS_EVSTAT: s_d.dat = {29'h0, s_q.ev};
        `TTM_OFS_EVEN:   s_d.dat = {29'h0, s_q.ev_en};
        default:         s_d.dat = 32'h0000_0000;
      endcase
    end

    // millisecond tick runs only while dwelling
    if (s_q.st == ttm_pkg::ST_DWELL)
    begin
      if (s_q.ms_cnt >= 32'(MS_CYC - 1))
      begin
        s_d.ms_cnt    = 32'h0000_0000;
        s_d.dwell_cnt = s_q.dwell_cnt + 16'h0001;
        if (s_q.dwell_cnt + 16'h0001 >= s_q.dwell)
        begin
          s_d.st = ttm_pkg::ST_IN;                   // see RULE9
          ev_set[`TTM_EV_ENTER] = 1'b1;              // see RULE11
        end
      end
      else
        s_d.ms_cnt = s_q.ms_cnt + 32'h0000_0001;
    end

    // new sample: latched in every mode, then judged against the band
    if (MEAS_VLD_I)
    begin
      s_d.meas = MEAS_I;                             // see RULE2
      if (!in_band)
      begin
        s_d.st        = ttm_pkg::ST_OUT;             // see RULE13
        s_d.dwell_cnt = 16'h0000;
        s_d.ms_cnt    = 32'h0000_0000;
      end
      else if (s_q.st == ttm_pkg::ST_OUT)
      begin
        s_d.st        = ttm_pkg::ST_DWELL;
        s_d.dwell_cnt = 16'h0000;
        s_d.ms_cnt    = 32'h0000_0000;
      end
    end

    // a set point change wins over a sample in the same cycle
    if (setpt_wr)
    begin
      s_d.st        = ttm_pkg::ST_OUT;               // see RULE13
      s_d.dwell_cnt = 16'h0000;
      s_d.ms_cnt    = 32'h0000_0000;
    end

    // leaving tolerance by any path is an event
    if (s_q.st == ttm_pkg::ST_IN && s_d.st != ttm_pkg::ST_IN)
      ev_set[`TTM_EV_EXIT] = 1'b1;                   // see RULE11
    s_d.in_tol = (s_d.st == ttm_pkg::ST_IN);         // see RULE9

    // completion waits for tolerance after switch-on or set point change
    if (on_rise || setpt_wr)
    begin
      s_d.opc      = 1'b0;                           // see RULE10
      s_d.opc_pend = 1'b1;
    end
    else if (s_q.opc_pend && s_q.in_tol)
    begin
      s_d.opc      = 1'b1;                           // see RULE10
      s_d.opc_pend = 1'b0;
    end

    // sticky events: a set in the clearing cycle is kept
    if (wr && ADR_I == `TTM_OFS_EVCLR)
      s_d.ev = (s_q.ev & ~wv[2:0]) | ev_set;
    else
      s_d.ev = s_q.ev | ev_set;                      // see RULE11
    s_d.irq = |(s_d.ev & s_d.ev_en);
  end

  // state register; reset loads the default band and window
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      s_q          <= '0;
      s_q.band     <= `TTM_BAND_RST;                 // see RULE6
      s_q.dwell    <= `TTM_DWELL_RST;                // see RULE6
      s_q.st       <= ttm_pkg::ST_OUT;
    end
    else
      s_q <= s_d;
  end

  assign DAT_O        = s_q.dat;
  assign ACK_O        = s_q.ack;
  assign IRQ_O        = s_q.irq;
  assign SAMPLE_REQ_O = s_q.samp_req;
  assign IN_TOL_O     = s_q.in_tol;
  assign OPC_O        = s_q.opc;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  chk_sample_pulse: assert property ( // see RULE1
    SAMPLE_REQ_O |=> !SAMPLE_REQ_O && s_q.samp_cnt == 32'h1)
    else $error("sample request not a one-cycle pulse");
  chk_meas_latch: assert property (MEAS_VLD_I |=> s_q.meas == $past(MEAS_I)) // see RULE2
    else $error("sample not latched");
  chk_band_range: assert property ( // see RULE4
    s_q.band >= `TTM_BAND_MIN && s_q.band <= `TTM_BAND_MAX)
    else $error("band out of range");
  chk_dwell_range: assert property ( // see RULE5
    s_q.dwell >= `TTM_DWELL_MIN && s_q.dwell <= `TTM_DWELL_MAX)
    else $error("dwell out of range");
  chk_reset_values: assert property ( // see RULE6
    $past(RST_I) |-> s_q.band == `TTM_BAND_RST && s_q.dwell == `TTM_DWELL_RST)
    else $error("reset band or dwell wrong");
  // window taken before the entry edge: a dwell write on that edge must not count
  chk_tol_entry: assert property ( // see RULE9
    $rose(IN_TOL_O) |-> $past(s_q.st) == ttm_pkg::ST_DWELL
                        && s_q.dwell_cnt >= $past(s_q.dwell))
    else $error("in tolerance before dwell elapsed");
  chk_setpt_restart: assert property ( // see RULE13
    setpt_wr |=> !IN_TOL_O && s_q.dwell_cnt == 16'h0)
    else $error("set point change did not restart dwell");
  // completion follows the tolerance seen one cycle earlier
  chk_opc_gate: assert property ($rose(OPC_O) |-> $past(IN_TOL_O)) // see RULE10
    else $error("completion set outside tolerance");
  chk_exit_event: assert property ($fell(IN_TOL_O) |-> s_q.ev[`TTM_EV_EXIT]) // see RULE11
    else $error("exit event not latched");
  chk_band_readback: assert property ( // see RULE12
    rd && ADR_I == `TTM_OFS_BAND |=> DAT_O == {24'h0, $past(s_q.band)} && ACK_O)
    else $error("band readback wrong");

  cov_enter_tol: cover property ($rose(IN_TOL_O));
  cov_exit_tol: cover property ($fell(IN_TOL_O));
  cov_opc_done: cover property ($rose(OPC_O));
  cov_reject: cover property ($rose(s_q.ev[`TTM_EV_REJECT]));

endmodule
`default_nettype wire
